// [src/icdma_pkg.sv]
/*
  Shared constants and carrier types for the channel transfer controller,
  its request controller and the bit input / bit output registers.
  Assumes a single 2X clock domain and a plain register port.
*/
package icdma_pkg;
  localparam int NCH = 8;
  localparam int CH_W = 3;
  localparam int DW = 32;
  localparam int AW = 8;
  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DMA_EN = 8'h04;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h08;
  localparam logic [7:0] OFS_BIT_IN = 8'h0C;
  localparam logic [7:0] OFS_BIT_OUT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CHCFG = 8'h20;
  localparam logic [7:0] OFS_GREG = 8'h40;
  localparam logic [7:0] OFS_BITOUT_BIT = 8'h60;
  localparam logic [7:0] OFS_BLOCK_MASK = 8'hE0;
  // --------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------
  localparam int CTRL_REVOLVE = 0;
  localparam int CTRL_PIN_SEL = 1;
  localparam int CFG_MEM_CELL = 2;
  localparam int CFG_DIS_PAGE = 3;
  localparam int G_IRQ_EN = 0;
  localparam int G_DEV_SEL = 31;
  localparam int G_INC_LO = 2;
  localparam int G_INC_HI = 15;
  localparam int G_PAGE_HI = 9;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CFG = 4'h0;
  localparam logic [31:0] RST_GREG = 32'h0000_0000;
  // --------------------------------------------------------------
  // transfer types and bus cycle counts
  // --------------------------------------------------------------
  localparam logic [1:0] TYPE_FOUR_BYTE = 2'h0;
  localparam logic [1:0] TYPE_ONE_BYTE = 2'h1;
  localparam logic [1:0] TYPE_CELL = 2'h2;
  localparam logic [2:0] CYC_SINGLE = 3'h1;
  localparam logic [2:0] CYC_FLYBY_FOUR = 3'h4;
  localparam logic [2:0] CYC_BUFFERED = 3'h5;
  localparam int SYNC_HOLD = 4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PRIO_NS = 100;
  localparam int PRIO_CYCLES = (PRIO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [CH_W-1:0] ch;
    logic [DW-1:0] addr;
    logic [2:0] cycles;
    logic buffered;
  } icdma_xact_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } icdma_reg_req_t;
endpackage : icdma_pkg

// [src/icdma_top.sv]
/*
  Eight-channel transfer controller with request controller, bit input
  synchroniser and bit output register, all on the 2X clock.
  Assumes the memory interface accepts xact_o and runs it for the cycle
  count given, the coprocessor drives its delay count, transfer, request
  and bit-output strobes on this clock, and devices drop a request once served.
*/
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module icdma_top #(
  parameter int DLY_W = 16,
  parameter int BUS_CYC_CLKS = 2,
  parameter int MPU_XACT_CYC = 1,
  parameter logic [31:0] VEC_BASE = 32'h0000_0100,
  parameter logic [31:0] VEC_STEP = 32'h0000_0010
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [7:0] in_pin_i,
  input wire logic [7:0] in_mux_i,
  output logic [7:0] bit_out_o,
  input wire logic [DLY_W-1:0] cop_delay_i,
  input wire logic cop_xfer_i,
  input wire logic [2:0] cop_xfer_ch_i,
  input wire logic [7:0] cop_int_i,
  input wire logic [7:0] cop_out_set_i,
  input wire logic [7:0] cop_out_clr_i,
  input wire logic mpu_req_i,
  output logic mpu_grant_o,
  output icdma_pkg::icdma_xact_t xact_o,
  output logic xact_start_o,
  output logic bus_busy_o,
  output logic dev_sel_o,
  output logic [7:0] irq_o,
  output logic irq_any_o,
  output logic [31:0] irq_vector_o
);
  localparam int N = icdma_pkg::NCH;
  localparam int CW = icdma_pkg::CH_W;

  // refused at elaboration: counts that the slot check or cycle counter cannot hold
  if (DLY_W < 8 || BUS_CYC_CLKS < 1 || MPU_XACT_CYC < 1 || MPU_XACT_CYC > 7) begin : g_param_check
    $error("icdma_top: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // reset release and register request
  // ----------------------------------------------------------------
  logic rst_a;
  logic rst_b;
  wire logic rst_n = rst_b;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_a <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_b <= rst_a;
    end
  end

  icdma_pkg::icdma_reg_req_t rq;
  assign rq = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // first set bit at or after start, wrapping; {found, index}
  function automatic logic [CW:0] pick(input logic [N-1:0] req, input logic [CW-1:0] start);
    logic [CW:0] res;
    logic [CW-1:0] idx;
    res = '0;
    for (int k = N - 1; k >= 0; k--) begin
      idx = start + CW'(k);
      if (req[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : pick

  function automatic logic [2:0] cycles_of(input logic [1:0] typ, input logic mem_cell);
    if (typ == icdma_pkg::TYPE_FOUR_BYTE) begin
      return mem_cell ? icdma_pkg::CYC_BUFFERED : icdma_pkg::CYC_FLYBY_FOUR;
    end else if (typ == icdma_pkg::TYPE_CELL && !mem_cell) begin
      return icdma_pkg::CYC_BUFFERED;
    end
    return icdma_pkg::CYC_SINGLE;
  endfunction : cycles_of

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0] ctrl;
  logic [7:0] dma_en;
  logic [7:0] irq_pend;
  logic [7:0] bit_in;
  logic [7:0] bit_out;
  logic [3:0] chcfg [N];
  logic [31:0] greg [N];
  logic [CW-1:0] rot;

  wire logic blk_cfg = (rq.addr & icdma_pkg::OFS_BLOCK_MASK) == icdma_pkg::OFS_CHCFG;
  wire logic blk_greg = (rq.addr & icdma_pkg::OFS_BLOCK_MASK) == icdma_pkg::OFS_GREG;
  wire logic blk_bit = (rq.addr & icdma_pkg::OFS_BLOCK_MASK) == icdma_pkg::OFS_BITOUT_BIT;
  wire logic [CW-1:0] sel = rq.addr[CW+1:2];
  wire logic aligned = (rq.addr[1:0] == 2'h0);
  wire logic wr_ctrl = rq.wr && rq.addr == icdma_pkg::OFS_CTRL;
  wire logic wr_en = rq.wr && rq.addr == icdma_pkg::OFS_DMA_EN;
  wire logic wr_pend = rq.wr && rq.addr == icdma_pkg::OFS_IRQ_PEND;
  wire logic wr_out = rq.wr && rq.addr == icdma_pkg::OFS_BIT_OUT;
  wire logic wr_cfg = rq.wr && blk_cfg && aligned;
  wire logic wr_greg = rq.wr && blk_greg && aligned;
  wire logic wr_obit = rq.wr && blk_bit && aligned;

  // ----------------------------------------------------------------
  // bit input synchroniser
  // ----------------------------------------------------------------
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] s3;
  logic [7:0] filt;
  logic [1:0] phase;
  wire logic [7:0] raw_in = ctrl[icdma_pkg::CTRL_PIN_SEL] ? in_pin_i : in_mux_i;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 8'hFF;
      s2 <= 8'hFF;
      s3 <= 8'hFF;
    end else if (ce_i) begin
      s1 <= raw_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // bit_in takes the filtered value every four cycles; a second holding stage
  // would push the worst pin-to-register delay past eight cycles
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      filt <= 8'hFF;
      bit_in <= 8'hFF;
      phase <= 2'h0;
    end else if (ce_i) begin
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
      phase <= phase + 2'h1;
      if (phase == 2'(icdma_pkg::SYNC_HOLD - 1)) begin
        bit_in <= filt;
      end
    end
  end

  // ----------------------------------------------------------------
  // prioritisation and slot check
  // ----------------------------------------------------------------
  logic cand_v;
  logic [CW-1:0] cand_ch;
  logic gnt_v;
  icdma_pkg::icdma_xact_t gnt_x;
  logic busy;
  logic [2:0] cyc_idx;
  logic [15:0] sub;
  icdma_pkg::icdma_xact_t cur;

  wire logic [N-1:0] chan_req = ~bit_in & dma_en;
  wire logic [N-1:0] masked = chan_req & ~(busy ? (8'h01 << cur.ch) : 8'h00)
    & ~(gnt_v ? (8'h01 << gnt_x.ch) : 8'h00);
  wire logic [CW-1:0] start_at = ctrl[icdma_pkg::CTRL_REVOLVE] ? rot : '0;
  wire logic [CW:0] pk = pick(masked, start_at);
  wire logic [2:0] cand_cyc = cycles_of(chcfg[cand_ch][1:0], chcfg[cand_ch][icdma_pkg::CFG_MEM_CELL]);
  wire logic [DLY_W-1:0] need_ch = DLY_W'(cand_cyc) * DLY_W'(BUS_CYC_CLKS);
  wire logic [DLY_W-1:0] need_mpu = DLY_W'(MPU_XACT_CYC) * DLY_W'(BUS_CYC_CLKS);
  wire logic last_clk = busy && sub == 16'(BUS_CYC_CLKS - 1) && cyc_idx == cur.cycles - 3'h1;
  wire logic near_end = (!busy || last_clk) && !gnt_v;
  wire logic cop_owns = (cop_delay_i == '0);
  wire logic ch_ok = cand_v && masked[cand_ch] && near_end && !cop_owns
    && cop_delay_i > need_ch;
  wire logic mpu_ok = mpu_req_i && !ch_ok && near_end && !cop_owns
    && cop_delay_i > need_mpu;
  wire logic cop_go = cop_xfer_i && cop_owns && (!busy || last_clk);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cand_v <= 1'b0;
      cand_ch <= '0;
      rot <= '0;
      gnt_v <= 1'b0;
      gnt_x <= '0;
      mpu_grant_o <= 1'b0;
    end else if (ce_i) begin
      cand_v <= pk[CW];
      cand_ch <= pk[CW-1:0];
      mpu_grant_o <= mpu_ok;
      gnt_v <= ch_ok;
      if (ch_ok) begin
        gnt_x <= '{ch: cand_ch, addr: greg[cand_ch], cycles: cand_cyc,
                   buffered: cand_cyc == icdma_pkg::CYC_BUFFERED};
        rot <= cand_ch + CW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // transaction sequencing
  // ----------------------------------------------------------------
  wire logic [2:0] cop_cyc = cycles_of(chcfg[cop_xfer_ch_i][1:0],
    chcfg[cop_xfer_ch_i][icdma_pkg::CFG_MEM_CELL]);
  wire logic start = gnt_v || cop_go;
  icdma_pkg::icdma_xact_t next_x;
  assign next_x = cop_go ? '{ch: cop_xfer_ch_i, addr: greg[cop_xfer_ch_i], cycles: cop_cyc,
    buffered: cop_cyc == icdma_pkg::CYC_BUFFERED} : gnt_x;
  wire logic [31:0] next_addr = {16'h0000, cur.addr[15:2] + 14'h0001, 2'h0};
  wire logic page_end = next_addr[icdma_pkg::G_PAGE_HI:icdma_pkg::G_INC_LO] == 8'h00;
  wire logic done = last_clk;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cyc_idx <= 3'h0;
      sub <= 16'h0000;
      cur <= '0;
      xact_start_o <= 1'b0;
      dev_sel_o <= 1'b0;
    end else if (ce_i) begin
      xact_start_o <= start;
      if (start) begin
        busy <= 1'b1;
        cur <= next_x;
        cyc_idx <= 3'h0;
        sub <= 16'h0000;
      end else if (done) begin
        busy <= 1'b0;
      end else if (busy) begin
        sub <= (sub == 16'(BUS_CYC_CLKS - 1)) ? 16'h0000 : sub + 16'h0001;
        if (sub == 16'(BUS_CYC_CLKS - 1)) begin
          cyc_idx <= cyc_idx + 3'h1;
        end
      end
      // in a buffered four-byte transfer the device is selected on the four byte cycles, memory on the fifth
      if (start) begin
        dev_sel_o <= next_x.addr[icdma_pkg::G_DEV_SEL];
      end else if (busy && sub == 16'(BUS_CYC_CLKS - 1) && cur.buffered) begin
        dev_sel_o <= cur.addr[icdma_pkg::G_DEV_SEL]
          && (chcfg[cur.ch][1:0] == icdma_pkg::TYPE_FOUR_BYTE ? cyc_idx < 3'h3 : 1'b0);
      end else if (done) begin
        dev_sel_o <= 1'b0;
      end
    end
  end
  assign xact_o = cur;
  assign bus_busy_o = busy;

  // ----------------------------------------------------------------
  // register writes and hardware updates
  // ----------------------------------------------------------------
  wire logic [7:0] page_hit = (done && page_end) ? (8'h01 << cur.ch) : 8'h00;
  logic [7:0] page_irq;
  logic [7:0] page_dis;
  always_comb begin
    page_irq = 8'h00;
    page_dis = 8'h00;
    for (int i = 0; i < N; i++) begin
      page_irq[i] = page_hit[i] && greg[i][icdma_pkg::G_IRQ_EN];
      page_dis[i] = page_hit[i] && chcfg[i][icdma_pkg::CFG_DIS_PAGE];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= icdma_pkg::RST_CTRL;
      dma_en <= icdma_pkg::RST_BYTE;
      irq_pend <= icdma_pkg::RST_BYTE;
      bit_out <= icdma_pkg::RST_BYTE;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl <= rq.wdata[1:0];
      end
      dma_en <= (wr_en ? rq.wdata[7:0] : dma_en) & ~page_dis;
      // a new event wins over a same-cycle clear
      irq_pend <= (irq_pend & ~(wr_pend ? rq.wdata[7:0] : 8'h00)) | page_irq | cop_int_i;
      bit_out <= ((wr_out ? rq.wdata[7:0] : bit_out)
        & ~(wr_obit ? (8'h01 << sel) : 8'h00) | (wr_obit && rq.wdata[0] ? (8'h01 << sel) : 8'h00)
        | cop_out_set_i) & ~cop_out_clr_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          chcfg[g] <= icdma_pkg::RST_CFG;
          greg[g] <= icdma_pkg::RST_GREG;
        end else if (ce_i) begin
          if (wr_cfg && sel == CW'(g)) begin
            chcfg[g] <= rq.wdata[3:0];
          end
          if (done && cur.ch == CW'(g)) begin
            greg[g] <= {greg[g][31:16], next_addr[15:2], greg[g][1:0]};
          end else if (wr_greg && sel == CW'(g)) begin
            greg[g] <= rq.wdata;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt requests and read port
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  wire logic [7:0] irq_all = ~bit_in | irq_pend;
  wire logic [CW:0] irq_pk = pick(irq_all, '0);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 8'h00;
      irq_any_o <= 1'b0;
      irq_vector_o <= 32'h0000_0000;
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      irq_o <= irq_all;
      irq_any_o <= irq_pk[CW];
      irq_vector_o <= VEC_BASE + VEC_STEP * 32'(irq_pk[CW-1:0]);
      reg_rdata_o <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (!rq.rd) begin
      rd_mux = 32'h0000_0000;
    end else if (rq.addr == icdma_pkg::OFS_CTRL) begin
      rd_mux = {30'h0, ctrl};
    end else if (rq.addr == icdma_pkg::OFS_DMA_EN) begin
      rd_mux = {24'h0, dma_en};
    end else if (rq.addr == icdma_pkg::OFS_IRQ_PEND) begin
      rd_mux = {24'h0, irq_pend};
    end else if (rq.addr == icdma_pkg::OFS_BIT_IN) begin
      rd_mux = {24'h0, bit_in};
    end else if (rq.addr == icdma_pkg::OFS_BIT_OUT) begin
      rd_mux = {24'h0, bit_out};
    end else if (rq.addr == icdma_pkg::OFS_STATUS) begin
      rd_mux = {24'h0, rot, cur.ch, gnt_v, busy};
    end else if (blk_cfg && aligned) begin
      rd_mux = {28'h0, chcfg[sel]};
    end else if (blk_greg && aligned) begin
      rd_mux = greg[sel];
    end else if (blk_bit && aligned) begin
      rd_mux = {31'h0, bit_out[sel]};
    end
  end
  assign bit_out_o = bit_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_granted;
    ce_i && ch_ok;
  endsequence
  sequence s_started;
    xact_start_o && bus_busy_o;
  endsequence

  a_grant_starts: assert property (@(posedge clock_i) disable iff (!rst_n)
    s_granted ##1 ce_i |=> s_started)
    else $error("granted transfer did not start next cycle");
  a_slot_fits: assert property (@(posedge clock_i) disable iff (!rst_n)
    ch_ok |-> cop_delay_i > need_ch && (!busy || last_clk))
    else $error("channel granted without room in slot");
  a_zero_delay: assert property (@(posedge clock_i) disable iff (!rst_n)
    cop_delay_i == '0 && ce_i |=> !gnt_v && !mpu_grant_o)
    else $error("grant given while coprocessor owns bus");
  a_chan_first: assert property (@(posedge clock_i) disable iff (!rst_n)
    ce_i && ch_ok && mpu_req_i |=> !mpu_grant_o)
    else $error("main processor won over channel");
  a_prio_delay: assert property (@(posedge clock_i) disable iff (!rst_n)
    gnt_v |-> $past(cand_v, 2) || $past(cand_v))
    else $error("bus request without prioritising cycle");
  a_atomic_xact: assert property (@(posedge clock_i) disable iff (!rst_n)
    busy && !last_clk && ce_i |=> busy && $stable(cur.ch))
    else $error("transaction broken before its last cycle");
  a_addr_step: assert property (@(posedge clock_i) disable iff (!rst_n)
    ce_i && done |=> greg[$past(cur.ch)][15:2] == $past(cur.addr[15:2]) + 14'h0001)
    else $error("memory address not advanced");
  a_page_irq: assert property (@(posedge clock_i) disable iff (!rst_n)
    ce_i && done && page_end && greg[cur.ch][0] |=> irq_pend[$past(cur.ch)] ##1 irq_o[$past(cur.ch, 2)])
    else $error("page end interrupt missing");
  a_cop_out: assert property (@(posedge clock_i) disable iff (!rst_n)
    ce_i && cop_out_set_i[0] && !cop_out_clr_i[0] |=> bit_out_o[0])
    else $error("coprocessor bit output set lost");
endmodule : icdma_top

// [testbench/icdma_dev_model.sv]
/*
  Behavioural model of the request lines of eight I/O devices.
  Assumes the bench pulses ask_i to make a device request service.
*/
`timescale 1ns/1ps
module icdma_dev_model (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [7:0] ask_i,
  input wire logic xact_start_i,
  input wire icdma_pkg::icdma_xact_t xact_i,
  output logic [7:0] req_n_o
);
  logic [7:0] pend;
  wire logic [7:0] served = (xact_start_i && xact_i.addr[31]) ? 8'h01 << xact_i.ch : 8'h00;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend <= 8'h00;
    end else begin
      pend <= (pend | ask_i) & ~served;
    end
  end
  // released lines sit at the pull-up level
  assign req_n_o = ~pend;
endmodule : icdma_dev_model

// [testbench/tb_icdma_top.sv]
/*
  Self-checking bench for icdma_top: register tasks and transfer scenarios.
  Assumes icdma_dev_model drives the pin bit inputs.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); end end
module tb_icdma_top;
  // ------
  // signals
  // ------
  localparam logic [17:0] CYC_TAB = {3'h1, 3'h5, 3'h1, 3'h1, 3'h5, 3'h4};
  localparam logic [5:0] BUF_TAB = 6'b010010;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic cop_xfer_i = 1'b0;
  logic [2:0] cop_xfer_ch_i = 3'h0;
  logic [15:0] cop_delay_i = 16'h0;
  logic [7:0] in_mux_i = 8'hFF;
  logic [7:0] ask = 8'h00;
  logic [7:0] cop_int_i = 8'h00;
  logic [7:0] cop_out_set_i = 8'h00;
  logic [7:0] cop_out_clr_i = 8'h00;
  logic ce_i = 1'b1;
  logic mpu_req_i = 1'b0;
  logic [31:0] reg_rdata_o, irq_vector_o;
  logic [7:0] in_pin_i, bit_out_o, irq_o;
  logic mpu_grant_o, xact_start_o, bus_busy_o, dev_sel_o, irq_any_o;
  icdma_pkg::icdma_xact_t xact_o;
  int bad_count = 0;
  int check_count = 0;

  always #50 clock_i = ~clock_i;

  icdma_top icdma_top_inst (.clock_i, .reset_n_i, .ce_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .in_pin_i, .in_mux_i, .bit_out_o, .cop_delay_i,
    .cop_xfer_i, .cop_xfer_ch_i, .cop_int_i, .cop_out_set_i, .cop_out_clr_i,
    .mpu_req_i, .mpu_grant_o, .xact_o, .xact_start_o, .bus_busy_o, .dev_sel_o,
    .irq_o, .irq_any_o, .irq_vector_o);
  icdma_dev_model icdma_dev_model_inst (.clock_i, .reset_n_i, .ask_i(ask),
    .xact_start_i(xact_start_o), .xact_i(xact_o), .req_n_o(in_pin_i));

  // ------
  // tasks
  // ------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask : rd
  task automatic go(input logic [7:0] m);
    @(posedge clock_i);
    ask <= m;
    @(posedge clock_i);
    ask <= 8'h00;
  endtask : go
  task automatic xfer(input logic [2:0] c);
    @(posedge clock_i);
    cop_xfer_i <= 1'b1;
    cop_xfer_ch_i <= c;
    @(posedge clock_i);
    cop_xfer_i <= 1'b0;
  endtask : xfer
  // bounded wait for a start, then the length of the busy span
  task automatic wait_xact(input logic [2:0] ch, input logic [2:0] cy, input logic bf);
    int n;
    n = 0;
    #1;
    while (xact_start_o !== 1'b1 && n < 80) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK(xact_start_o, 1'b1)
    `CHK(xact_o.ch, ch)
    `CHK(xact_o.cycles, cy)
    `CHK(xact_o.buffered, bf)
    `CHK(dev_sel_o, 1'b1)
    n = 0;
    while (bus_busy_o === 1'b1 && n < 20) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK(n, int'(cy) * 2)
  endtask : wait_xact
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // ------
  // scenarios
  // ------
  initial begin
    cyc(12);
    reset_n_i <= 1'b1;
    cyc(4);
    rd(icdma_pkg::OFS_CTRL, 32'h0);
    rd(icdma_pkg::OFS_DMA_EN, 32'h0);
    rd(icdma_pkg::OFS_BIT_IN, 32'hFF);
    rd(8'h1C, 32'h0);
    wr(icdma_pkg::OFS_BIT_OUT, 32'hA5);
    rd(icdma_pkg::OFS_BIT_OUT, 32'hA5);
    wr(icdma_pkg::OFS_BITOUT_BIT + 8'h04, 32'h1);
    rd(icdma_pkg::OFS_BIT_OUT, 32'hA7);
    @(posedge clock_i);
    cop_out_set_i <= 8'h10;
    cop_out_clr_i <= 8'h01;
    @(posedge clock_i);
    cop_out_set_i <= 8'h00;
    cop_out_clr_i <= 8'h00;
    #1;
    `CHK(bit_out_o, 8'hB6)
    // clock enable low: the write must not land
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr(icdma_pkg::OFS_BIT_OUT, 32'h00);
    ce_i <= 1'b1;
    rd(icdma_pkg::OFS_BIT_OUT, 32'hB6);
    // multiplexed source is selected out of reset; eight edges at most to bit_in
    in_mux_i <= 8'h7F;
    cyc(7);
    rd(icdma_pkg::OFS_BIT_IN, 32'h7F);
    `CHK(irq_o[7], 1'b1)
    in_mux_i <= 8'hFF;
    wr(icdma_pkg::OFS_CTRL, 32'h2);
    cop_delay_i <= 16'h0100;
    for (int c = 0; c < 8; c++) wr(icdma_pkg::OFS_GREG + 8'(4 * c), 32'h8000_0000);
    wr(icdma_pkg::OFS_CHCFG + 8'h04, 32'h1);
    wr(icdma_pkg::OFS_CHCFG + 8'h14, 32'h1);
    wr(icdma_pkg::OFS_DMA_EN, 32'h23);
    cyc(14);
    for (int i = 0; i < 6; i++) begin
      wr(icdma_pkg::OFS_CHCFG, 32'(i % 2 * 4 + i / 2));
      go(8'h01);
      wait_xact(3'h0, CYC_TAB[3 * i +: 3], BUF_TAB[i]);
      cyc(30);
    end
    go(8'h22);
    wait_xact(3'h1, 3'h1, 1'b0);
    cyc(30);
    wr(icdma_pkg::OFS_CTRL, 32'h3);
    go(8'h02);
    wait_xact(3'h1, 3'h1, 1'b0);
    cyc(30);
    go(8'h22);
    wait_xact(3'h5, 3'h1, 1'b0);
    cyc(40);
    // slot must exceed two clocks for a one-cycle transfer
    cop_delay_i <= 16'h0;
    mpu_req_i <= 1'b1;
    go(8'h02);
    cyc(30);
    #1;
    `CHK(in_pin_i[1], 1'b0)
    `CHK(mpu_grant_o, 1'b0)
    @(posedge clock_i);
    cop_delay_i <= 16'h2;
    cyc(30);
    #1;
    `CHK(in_pin_i[1], 1'b0)
    `CHK(mpu_grant_o, 1'b0)
    @(posedge clock_i);
    cop_delay_i <= 16'h3;
    wait_xact(3'h1, 3'h1, 1'b0);
    cyc(30);
    #1;
    `CHK(mpu_grant_o, 1'b1)
    @(posedge clock_i);
    cop_delay_i <= 16'h0;
    mpu_req_i <= 1'b0;
    wr(icdma_pkg::OFS_GREG + 8'h08, 32'h8000_03FD);
    wr(icdma_pkg::OFS_GREG + 8'h18, 32'h8000_03FC);
    wr(icdma_pkg::OFS_CHCFG + 8'h08, 32'h9);
    wr(icdma_pkg::OFS_CHCFG + 8'h18, 32'h1);
    wr(icdma_pkg::OFS_IRQ_PEND, 32'hFF);
    wr(icdma_pkg::OFS_DMA_EN, 32'h44);
    xfer(3'h6);
    wait_xact(3'h6, 3'h1, 1'b0);
    xfer(3'h2);
    wait_xact(3'h2, 3'h1, 1'b0);
    rd(icdma_pkg::OFS_GREG + 8'h18, 32'h8000_0400);
    rd(icdma_pkg::OFS_GREG + 8'h08, 32'h8000_0401);
    rd(icdma_pkg::OFS_IRQ_PEND, 32'h04);
    `CHK(irq_o, 8'h04)
    `CHK(irq_vector_o, 32'h0000_0120)
    rd(icdma_pkg::OFS_DMA_EN, 32'h40);
    wr(icdma_pkg::OFS_IRQ_PEND, 32'h04);
    @(posedge clock_i);
    cop_int_i <= 8'h08;
    @(posedge clock_i);
    cop_int_i <= 8'h00;
    cyc(2);
    #1;
    `CHK(irq_o, 8'h08)
    `CHK(irq_any_o, 1'b1)
    `CHK(irq_vector_o, 32'h0000_0130)
    wr(icdma_pkg::OFS_IRQ_PEND, 32'h08);
    cyc(2);
    #1;
    `CHK(irq_o, 8'h00)
    wrap_up();
  end

  initial begin
    cyc(6000);
    bad_count++;
    wrap_up();
  end
endmodule : tb_icdma_top
